// ### core/cswp_core.sv
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cswp_core (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  SYS_RST,
    // axi4-lite slave
    input  wire logic [7:0]            S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output var  logic                  S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output var  logic                  S_AXI_WREADY,
    output var  logic [1:0]            S_AXI_BRESP,
    output var  logic                  S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [7:0]            S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output var  logic                  S_AXI_ARREADY,
    output var  logic [31:0]           S_AXI_RDATA,
    output var  logic [1:0]            S_AXI_RRESP,
    output var  logic                  S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY,
    // instruction sequencing
    input  wire logic                  RESET_VEC_VALID,
    input  wire logic [15:0]           RESET_VEC,
    input  wire logic                  FETCH_ADV,
    input  wire logic [2:0]            FETCH_LEN,
    input  wire logic                  BRANCH,
    input  wire logic [19:0]           BRANCH_TARGET,
    // flag updates
    input  wire cswp_pkg::cswp_alu_s   ALU,
    input  wire cswp_pkg::cswp_bitop_s BITOP,
    input  wire cswp_pkg::cswp_ev_e    EVENT,
    input  wire logic [2:0]            BANK_SEL,
    input  wire logic [15:0]           RESTORE_WORD,
    // interrupt gating
    input  wire logic                  MASKABLE_REQ,
    input  wire logic                  NMI_REQ,
    input  wire logic                  MACRO_REQ,
    // outputs
    output var  logic [19:0]           PC,
    output var  logic [15:0]           PROGRAM_STATUS_WORD,
    output var  logic [15:0]           SAVE_WORD,
    output var  logic                  SAVE_TO_STACK,
    output var  logic                  SAVE_TO_PAIR,
    output var  logic                  INT_ACCEPT,
    output var  logic                  BIT_ACC,
    output var  logic [2:0]            ACC_REG,
    output var  logic [2:0]            IDX_REG,
    output var  logic [2:0]            CNT_HI_REG,
    output var  logic [2:0]            CNT_LO_REG,
    output var  logic [1:0]            ACC_PAIR,
    output var  logic [1:0]            CNT_PAIR
);
    logic [19:0] pc_reg;
    logic [15:0] psw_reg;
    logic [15:0] psw_next;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        do_write;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;

    // even count of ones
    function automatic logic parity_even(input logic [7:0] v);
        return ~(^v);
    endfunction

    // byte merge with the write mask
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] wmask);
        return (old_v & ~wmask) | (new_v & wmask);
    endfunction

    assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_take  = S_AXI_WVALID & S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    assign wr_addr = aw_hold_reg ? aw_addr_reg : S_AXI_AWADDR;
    assign wr_data = w_hold_reg ? w_data_reg : S_AXI_WDATA;
    assign wr_strb = w_hold_reg ? w_strb_reg : S_AXI_WSTRB;
    assign do_write = (aw_hold_reg | aw_take) & (w_hold_reg | w_take)
                    & ~S_AXI_BVALID;

    // write channels, taken in either order
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= cswp_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= ~aw_hold_reg & ~aw_take & ~do_write
                           & ~S_AXI_BVALID;
            S_AXI_WREADY  <= ~w_hold_reg & ~w_take & ~do_write
                           & ~S_AXI_BVALID;
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY  <= 1'b0;
                S_AXI_BRESP  <= (wr_addr == cswp_pkg::STATUS_WORD_LOW_ADDR
                              || wr_addr == cswp_pkg::STATUS_WORD_HIGH_ADDR)
                              ? cswp_pkg::RESP_OKAY : cswp_pkg::RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_reg <= 1'b1;
                end
                if (w_take) begin
                    w_hold_reg <= 1'b1;
                end
                if (S_AXI_BVALID & S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    // read channel
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= cswp_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take;
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= cswp_pkg::RESP_OKAY;
                case (S_AXI_ARADDR)
                    cswp_pkg::STATUS_WORD_LOW_ADDR:
                        S_AXI_RDATA <= {24'h00_0000, psw_reg[7:0]};
                    cswp_pkg::STATUS_WORD_HIGH_ADDR:
                        // undefined low nibble reads as zero
                        S_AXI_RDATA <= {24'h00_0000,
                                        psw_reg[15:8] & cswp_pkg::HIGH_WMASK};
                    cswp_pkg::PC_ADDR:
                        S_AXI_RDATA <= {12'h000, pc_reg};
                    cswp_pkg::BANK_MAP_ADDR:
                        S_AXI_RDATA <= {24'h00_0000, 1'b0, ACC_REG,
                                        1'b0, IDX_REG};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= cswp_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // program counter
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pc_reg <= 20'h0_0000;
        end else if (RESET_VEC_VALID) begin
            pc_reg <= {cswp_pkg::PC_UPPER_RESET, RESET_VEC};
        end else if (BRANCH) begin
            pc_reg <= BRANCH_TARGET;
        end else if (FETCH_ADV) begin
            pc_reg <= pc_reg + {17'h0_0000, FETCH_LEN};
        end
    end

    // status word next value; later sources win
    always_comb begin
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] res8;
        lo   = psw_reg[7:0];
        hi   = psw_reg[15:8];
        res8 = ALU.result[7:0];
        case (ALU.kind)
            cswp_pkg::CSWP_OP_ARITH: begin
                lo[cswp_pkg::CARRY_BIT] = ALU.carry_out;
                lo[cswp_pkg::PV_BIT] =
                    ALU.carry_msb_in ^ ALU.carry_out;
                lo[cswp_pkg::AC_BIT] = ALU.half_carry;
            end
            cswp_pkg::CSWP_OP_LOGIC, cswp_pkg::CSWP_OP_CHECK:
                lo[cswp_pkg::PV_BIT] = parity_even(res8);
            cswp_pkg::CSWP_OP_SHIFT8, cswp_pkg::CSWP_OP_SHIFT16: begin
                lo[cswp_pkg::CARRY_BIT] = ALU.shift_out;
                lo[cswp_pkg::PV_BIT] = parity_even(res8);
            end
            default: ;
        endcase
        if (ALU.kind != cswp_pkg::CSWP_OP_NONE) begin
            lo[cswp_pkg::ZF_BIT] = ALU.wide ? (ALU.result == 16'h0000)
                                            : (res8 == 8'h00);
            lo[cswp_pkg::SF_BIT] = ALU.wide ? ALU.result[15]
                                            : res8[7];
        end
        if (BITOP.valid) begin
            if (BITOP.high_half) begin
                case (BITOP.op)
                    cswp_pkg::BITOP_CLR: hi[BITOP.bit_pos] = 1'b0;
                    cswp_pkg::BITOP_SET: hi[BITOP.bit_pos] = 1'b1;
                    cswp_pkg::BITOP_NOT: hi[BITOP.bit_pos] = ~hi[BITOP.bit_pos];
                    default: lo[cswp_pkg::CARRY_BIT] = hi[BITOP.bit_pos];
                endcase
            end else begin
                case (BITOP.op)
                    cswp_pkg::BITOP_CLR: lo[BITOP.bit_pos] = 1'b0;
                    cswp_pkg::BITOP_SET: lo[BITOP.bit_pos] = 1'b1;
                    cswp_pkg::BITOP_NOT: lo[BITOP.bit_pos] = ~lo[BITOP.bit_pos];
                    default: lo[cswp_pkg::CARRY_BIT] = lo[BITOP.bit_pos];
                endcase
            end
        end
        case (EVENT)
            cswp_pkg::CSWP_EV_EI: lo[cswp_pkg::IE_BIT] = 1'b1;
            cswp_pkg::CSWP_EV_DI,
            cswp_pkg::CSWP_EV_IRQ_ACK:
                lo[cswp_pkg::IE_BIT] = 1'b0;
            cswp_pkg::CSWP_EV_RET_INT, cswp_pkg::CSWP_EV_RET_BRK,
            cswp_pkg::CSWP_EV_CTX_RET: begin
                {hi, lo} = RESTORE_WORD;
            end
            cswp_pkg::CSWP_EV_SEL_BANK:
                hi[cswp_pkg::BANK_LSB +: 3] = BANK_SEL;
            default: ;
        endcase
        if (do_write && wr_strb[0]) begin
            if (wr_addr == cswp_pkg::STATUS_WORD_LOW_ADDR) begin
                lo = merge(lo, wr_data[7:0], cswp_pkg::LOW_WMASK);
            end else if (wr_addr == cswp_pkg::STATUS_WORD_HIGH_ADDR) begin
                hi = merge(hi, wr_data[7:0], cswp_pkg::HIGH_WMASK);
            end
        end
        lo[cswp_pkg::ZERO1_BIT] = 1'b0;
        hi[3:0] = 4'h0;
        psw_next = {hi, lo};
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            psw_reg <= cswp_pkg::PSW_RESET;
        end else begin
            psw_reg <= psw_next;
        end
    end

    // save strobes for stack and fourth register pair
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SAVE_WORD     <= 16'h0000;
            SAVE_TO_STACK <= 1'b0;
            SAVE_TO_PAIR  <= 1'b0;
        end else begin
            SAVE_TO_STACK <= (EVENT == cswp_pkg::CSWP_EV_IRQ_ACK)
                           | (EVENT == cswp_pkg::CSWP_EV_BREAK);
            SAVE_TO_PAIR  <= (EVENT == cswp_pkg::CSWP_EV_CTX_SAVE);
            if (EVENT == cswp_pkg::CSWP_EV_IRQ_ACK
                || EVENT == cswp_pkg::CSWP_EV_BREAK
                || EVENT == cswp_pkg::CSWP_EV_CTX_SAVE) begin
                SAVE_WORD <= psw_reg;
            end
        end
    end

    // interrupt gate, register mapping and mirrors
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            INT_ACCEPT <= 1'b0;
            PC         <= 20'h0_0000;
            PROGRAM_STATUS_WORD        <= cswp_pkg::PSW_RESET;
            BIT_ACC    <= 1'b0;
            ACC_REG    <= 3'd1;
            IDX_REG    <= 3'd0;
            CNT_HI_REG <= 3'd3;
            CNT_LO_REG <= 3'd2;
            ACC_PAIR   <= 2'd0;
            CNT_PAIR   <= 2'd1;
        end else begin
            INT_ACCEPT <= NMI_REQ | MACRO_REQ
                        | (MASKABLE_REQ
                           & psw_next[cswp_pkg::IE_BIT]);
            PC      <= pc_reg;
            PROGRAM_STATUS_WORD     <= psw_next;
            BIT_ACC <= psw_next[cswp_pkg::CARRY_BIT];
            ACC_REG    <= {psw_next[cswp_pkg::RSS_BIT], 2'd1};
            IDX_REG    <= {psw_next[cswp_pkg::RSS_BIT], 2'd0};
            CNT_HI_REG <= {psw_next[cswp_pkg::RSS_BIT], 2'd3};
            CNT_LO_REG <= {psw_next[cswp_pkg::RSS_BIT], 2'd2};
            ACC_PAIR   <= {psw_next[cswp_pkg::RSS_BIT], 1'b0};
            CNT_PAIR   <= {psw_next[cswp_pkg::RSS_BIT], 1'b1};
        end
    end
endmodule
`default_nettype wire

// ### core/cswp_pkg.sv
package cswp_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] STATUS_WORD_LOW_ADDR  = 8'h00;
    localparam logic [7:0] STATUS_WORD_HIGH_ADDR = 8'h04;
    localparam logic [7:0] PC_ADDR               = 8'h08;
    localparam logic [7:0] BANK_MAP_ADDR         = 8'h0C;

    localparam int PC_W   = 20;
    localparam int WORD_W = 16;

    // low-half bit positions
    localparam int CARRY_BIT = 0;
    localparam int ZERO1_BIT = 1;
    localparam int PV_BIT    = 2;
    localparam int IE_BIT    = 3;
    localparam int AC_BIT    = 4;
    localparam int RSS_BIT   = 5;
    localparam int ZF_BIT    = 6;
    localparam int SF_BIT    = 7;
    // high-half bit positions
    localparam int BANK_LSB  = 4;
    localparam int USER_BIT  = 7;

    localparam logic [7:0]  LOW_WMASK  = 8'hFD;
    localparam logic [7:0]  HIGH_WMASK = 8'hF0;
    localparam logic [15:0] PSW_RESET  = 16'h0000;
    localparam logic [3:0]  PC_UPPER_RESET = 4'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        CSWP_OP_NONE,
        CSWP_OP_ARITH,
        CSWP_OP_LOGIC,
        CSWP_OP_SHIFT8,
        CSWP_OP_SHIFT16,
        CSWP_OP_CHECK
    } cswp_alu_e;

    typedef enum logic [3:0] {
        CSWP_EV_NONE,
        CSWP_EV_EI,
        CSWP_EV_DI,
        CSWP_EV_IRQ_ACK,
        CSWP_EV_BREAK,
        CSWP_EV_RET_INT,
        CSWP_EV_RET_BRK,
        CSWP_EV_CTX_SAVE,
        CSWP_EV_CTX_RET,
        CSWP_EV_SEL_BANK
    } cswp_ev_e;

    // flag result from the datapath
    typedef struct packed {
        cswp_alu_e   kind;
        logic        wide;
        logic [15:0] result;
        logic        carry_out;
        logic        carry_msb_in;
        logic        half_carry;
        logic        shift_out;
    } cswp_alu_s;

    // single-bit manipulation
    typedef struct packed {
        logic       valid;
        logic       high_half;
        logic [2:0] bit_pos;
        logic [1:0] op;
    } cswp_bitop_s;

    localparam logic [1:0] BITOP_CLR = 2'b00;
    localparam logic [1:0] BITOP_SET = 2'b01;
    localparam logic [1:0] BITOP_NOT = 2'b10;
    localparam logic [1:0] BITOP_MOV = 2'b11;
endpackage

// ### tb/cswp_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cswp_core_properties (
    // clock and reset
    input wire logic                  CLK,
    input wire logic                  SYS_RST,
    // sequencing
    input wire logic                  RESET_VEC_VALID,
    input wire logic [15:0]           RESET_VEC,
    input wire logic                  FETCH_ADV,
    input wire logic [2:0]            FETCH_LEN,
    input wire logic                  BRANCH,
    input wire logic [19:0]           BRANCH_TARGET,
    // flag sources and interrupt requests
    input wire cswp_pkg::cswp_alu_s   ALU,
    input wire cswp_pkg::cswp_bitop_s BITOP,
    input wire cswp_pkg::cswp_ev_e    EVENT,
    input wire logic [2:0]            BANK_SEL,
    input wire logic [15:0]           RESTORE_WORD,
    input wire logic                  MASKABLE_REQ,
    input wire logic                  NMI_REQ,
    input wire logic                  MACRO_REQ,
    // observed state
    input wire logic [19:0]           PC,
    input wire logic [15:0]           PROGRAM_STATUS_WORD,
    input wire logic [15:0]           SAVE_WORD,
    input wire logic                  SAVE_TO_STACK,
    input wire logic                  SAVE_TO_PAIR,
    input wire logic                  INT_ACCEPT,
    input wire logic [2:0]            ACC_REG,
    input wire logic [1:0]            CNT_PAIR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence ev_save;
        EVENT == cswp_pkg::CSWP_EV_IRQ_ACK || EVENT == cswp_pkg::CSWP_EV_BREAK;
    endsequence
    sequence ev_ret;
        EVENT == cswp_pkg::CSWP_EV_RET_INT || EVENT == cswp_pkg::CSWP_EV_RET_BRK
            || EVENT == cswp_pkg::CSWP_EV_CTX_RET;
    endsequence

    reset_clear_a: assert property (disable iff (1'b0) SYS_RST |=>
        PROGRAM_STATUS_WORD == 16'h0000 && PC == 20'h0_0000) else $error("reset not cleared");
    pc_vector_a: assert property (RESET_VEC_VALID |->
        ##2 PC == {4'h0, $past(RESET_VEC, 2)}) else $error("vector load");
    pc_branch_a: assert property (BRANCH && !RESET_VEC_VALID |->
        ##2 PC == $past(BRANCH_TARGET, 2)) else $error("branch load");
    pc_fetch_a: assert property (FETCH_ADV && !BRANCH && !RESET_VEC_VALID |->
        ##2 PC == 20'($past(PC) + $past(FETCH_LEN, 2))) else $error("fetch step");
    ie_set_a: assert property (EVENT == cswp_pkg::CSWP_EV_EI |=> PROGRAM_STATUS_WORD[3])
        else $error("ie not set");
    ie_clear_a: assert property (EVENT == cswp_pkg::CSWP_EV_DI ||
        EVENT == cswp_pkg::CSWP_EV_IRQ_ACK |=> !PROGRAM_STATUS_WORD[3]) else $error("ie kept");
    save_stack_a: assert property (ev_save |=> SAVE_TO_STACK &&
        SAVE_WORD == $past(PROGRAM_STATUS_WORD)) else $error("stack save");
    ctx_save_a: assert property (EVENT == cswp_pkg::CSWP_EV_CTX_SAVE |=>
        SAVE_TO_PAIR && SAVE_WORD == $past(PROGRAM_STATUS_WORD)) else $error("pair save");
    restore_word_a: assert property (ev_ret |=>
        PROGRAM_STATUS_WORD == ($past(RESTORE_WORD) & 16'hF0FD)) else $error("restore");
    int_gate_a: assert property (!$past(SYS_RST) |-> INT_ACCEPT ==
        ($past(NMI_REQ) || $past(MACRO_REQ) || ($past(MASKABLE_REQ) && PROGRAM_STATUS_WORD[3])))
        else $error("interrupt gating");
    bank_sel_a: assert property (EVENT == cswp_pkg::CSWP_EV_SEL_BANK |=>
        PROGRAM_STATUS_WORD[14:12] == $past(BANK_SEL)) else $error("bank select");
    reserved_zero_a: assert property ((PROGRAM_STATUS_WORD & 16'h0F02) == 16'h0000)
        else $error("reserved bits set");
    rss_map_a: assert property ($stable(PROGRAM_STATUS_WORD[5]) |->
        ACC_REG == (PROGRAM_STATUS_WORD[5] ? 3'h5 : 3'h1) && CNT_PAIR == (PROGRAM_STATUS_WORD[5] ? 2'h3 : 2'h1))
        else $error("set mapping");
    arith_flags_a: assert property (ALU.kind == cswp_pkg::CSWP_OP_ARITH &&
        !BITOP.valid && EVENT == cswp_pkg::CSWP_EV_NONE |=>
        PROGRAM_STATUS_WORD[2] == $past(ALU.carry_out ^ ALU.carry_msb_in) &&
        PROGRAM_STATUS_WORD[0] == $past(ALU.carry_out) && PROGRAM_STATUS_WORD[4] == $past(ALU.half_carry))
        else $error("arith flags");
endmodule
bind cswp_core cswp_core_properties u_cswp_core_properties (.*);
`default_nettype wire

// ### tb/cswp_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module cswp_core_test;
    logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
    logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, RESET_VEC_VALID;
    logic FETCH_ADV, BRANCH, MASKABLE_REQ, NMI_REQ, MACRO_REQ;
    logic SAVE_TO_STACK, SAVE_TO_PAIR, INT_ACCEPT, BIT_ACC;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, ACC_PAIR, CNT_PAIR, resp;
    logic [15:0] RESET_VEC, RESTORE_WORD, PROGRAM_STATUS_WORD, SAVE_WORD;
    logic [2:0]  FETCH_LEN, BANK_SEL, ACC_REG, IDX_REG, CNT_HI_REG, CNT_LO_REG;
    logic [19:0] BRANCH_TARGET, PC;
    cswp_pkg::cswp_alu_s   ALU;
    cswp_pkg::cswp_bitop_s BITOP;
    cswp_pkg::cswp_ev_e    EVENT;
    int error_cnt, tests_run;
    localparam logic [7:0] lo_a = cswp_pkg::STATUS_WORD_LOW_ADDR;
    localparam logic [7:0] hi_a = cswp_pkg::STATUS_WORD_HIGH_ADDR;

    cswp_core u_cswp_core (.*);

    always #5 CLK = ~CLK;

    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task limit(input int n);
        if (n >= 40) begin
            chk("handshake wait", 32'h0000_0000, 32'h0000_0001);
            summarize;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID && n < 40);
        resp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        limit(n);
    endtask

    task rdr(input logic [7:0] a);
        int n;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID && n < 40);
        rd = S_AXI_RDATA;
        resp = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        limit(n);
    endtask

    task ev(input cswp_pkg::cswp_ev_e e);
        @(posedge CLK);
        EVENT <= e;
        @(posedge CLK);
        EVENT <= cswp_pkg::CSWP_EV_NONE;
        #1;
    endtask

    task pcs(input logic v, input logic b, input logic f, input logic [2:0] l);
        @(posedge CLK);
        RESET_VEC_VALID <= v;
        BRANCH <= b;
        FETCH_ADV <= f;
        FETCH_LEN <= l;
    endtask

    task alu(input cswp_pkg::cswp_alu_e k, input logic [15:0] r,
             input logic [3:0] c, input logic [7:0] m, input logic [7:0] x);
        @(posedge CLK);
        // sixteen-bit shifts judge zero and sign on the whole word
        ALU <= '{k, k == cswp_pkg::CSWP_OP_SHIFT16, r, c[3], c[2], c[1], c[0]};
        @(posedge CLK);
        ALU <= '0;
        #1;
        chk("flags", PROGRAM_STATUS_WORD[7:0] & m, x);
    endtask

    task bop(input logic h, input logic [2:0] p, input logic [1:0] o);
        @(posedge CLK);
        BITOP <= '{1'b1, h, p, o};
        @(posedge CLK);
        BITOP <= '0;
        #1;
    endtask

    function automatic logic [23:0] regmap();
        return {1'b0, ACC_REG, 1'b0, IDX_REG, 1'b0, CNT_HI_REG, 1'b0, CNT_LO_REG,
                2'b00, ACC_PAIR, 2'b00, CNT_PAIR};
    endfunction

    task t_pc;
        pcs(1'b0, 1'b1, 1'b1, 3'h5);
        pcs(1'b0, 1'b0, 1'b1, 3'h1);
        pcs(1'b0, 1'b0, 1'b0, 3'h0);
        @(posedge CLK);
        #1;
        chk("pc branch", PC, 20'hF_FFFF);
        pcs(1'b1, 1'b1, 1'b1, 3'h2);
        pcs(1'b0, 1'b0, 1'b1, 3'h7);
        pcs(1'b0, 1'b0, 1'b1, 3'h1);
        pcs(1'b0, 1'b0, 1'b0, 3'h0);
        @(posedge CLK);
        #1;
        chk("pc vector", PC, 20'h0_A5CB);
        rdr(cswp_pkg::PC_ADDR);
        chk("pc read", rd[19:0], 20'h0_A5CB);
    endtask

    task t_regs;
        chk("reset map", regmap(), 24'h10_3201);
        rdr(lo_a);
        chk("low reset", rd[7:0], 8'h00);
        wr(lo_a, 32'h0000_00FF, 4'hF);
        chk("write okay", resp, cswp_pkg::RESP_OKAY);
        rdr(lo_a);
        chk("read okay", resp, cswp_pkg::RESP_OKAY);
        chk("low read", rd[7:0], 8'hFD);
        wr(hi_a, 32'h0000_00FF, 4'hF);
        rdr(hi_a);
        chk("high read", rd[7:0], 8'hF0);
        chk("word", PROGRAM_STATUS_WORD, 16'hF0FD);
        chk("rss map", regmap(), 24'h54_7623);
        rdr(cswp_pkg::BANK_MAP_ADDR);
        chk("map read", rd[7:0], 8'h54);
        wr(cswp_pkg::PC_ADDR, 32'h0000_0000, 4'hF);
        chk("ro write", resp, cswp_pkg::RESP_SLVERR);
        rdr(8'h10);
        chk("unmapped", resp, cswp_pkg::RESP_SLVERR);
        wr(lo_a, 32'h0000_0000, 4'h0);
        chk("no strobe", PROGRAM_STATUS_WORD, 16'hF0FD);
        wr(lo_a, 32'h0000_0000, 4'hF);
        wr(hi_a, 32'h0000_00A0, 4'hF);
        chk("bus write", PROGRAM_STATUS_WORD, 16'hA000);
    endtask

    task t_events;
        MASKABLE_REQ <= 1'b1;
        ev(cswp_pkg::CSWP_EV_EI);
        chk("ie set", {PROGRAM_STATUS_WORD, 15'h0000, INT_ACCEPT}, 32'hA008_0001);
        ev(cswp_pkg::CSWP_EV_IRQ_ACK);
        chk("ack", {SAVE_WORD, PROGRAM_STATUS_WORD}, 32'hA008_A000);
        chk("ack flags", {SAVE_TO_STACK, INT_ACCEPT}, 2'b10);
        for (int i = 0; i < 2; i++) begin
            @(posedge CLK);
            {MACRO_REQ, NMI_REQ} <= i[0] ? 2'b10 : 2'b01;
            @(posedge CLK);
            {MACRO_REQ, NMI_REQ} <= 2'b00;
            #1;
            chk("ie off accept", INT_ACCEPT, 1'b1);
        end
        RESTORE_WORD <= 16'hFFFF;
        ev(cswp_pkg::CSWP_EV_RET_INT);
        chk("interrupt_return_instr", PROGRAM_STATUS_WORD, 16'hF0FD);
        RESTORE_WORD <= 16'h1234;
        ev(cswp_pkg::CSWP_EV_RET_BRK);
        chk("break_return_instr", PROGRAM_STATUS_WORD, 16'h1034);
        ev(cswp_pkg::CSWP_EV_BREAK);
        chk("brk", {SAVE_TO_STACK, SAVE_WORD}, 17'h1_1034);
        ev(cswp_pkg::CSWP_EV_CTX_SAVE);
        chk("ctx", {SAVE_TO_PAIR, SAVE_WORD}, 17'h1_1034);
        RESTORE_WORD <= 16'h0F0A;
        ev(cswp_pkg::CSWP_EV_CTX_RET);
        chk("ctx ret", PROGRAM_STATUS_WORD, 16'h0008);
        ev(cswp_pkg::CSWP_EV_DI);
        chk("di", PROGRAM_STATUS_WORD, 16'h0000);
        for (int b = 0; b < 8; b++) begin
            BANK_SEL <= b[2:0];
            ev(cswp_pkg::CSWP_EV_SEL_BANK);
            chk("bank", PROGRAM_STATUS_WORD[14:12], b[2:0]);
        end
    endtask

    task t_alu;
        alu(cswp_pkg::CSWP_OP_ARITH, 16'h00E1, 4'h6, 8'hFF, 8'h94);
        alu(cswp_pkg::CSWP_OP_ARITH, 16'h0000, 4'hC, 8'hFF, 8'h41);
        alu(cswp_pkg::CSWP_OP_LOGIC, 16'h0003, 4'h0, 8'hC4, 8'h04);
        alu(cswp_pkg::CSWP_OP_CHECK, 16'h0007, 4'h0, 8'hC4, 8'h00);
        alu(cswp_pkg::CSWP_OP_SHIFT16, 16'h8100, 4'h1, 8'hC5, 8'h85);
        alu(cswp_pkg::CSWP_OP_SHIFT8, 16'h0001, 4'h0, 8'hC5, 8'h00);
        bop(1'b1, 3'h7, cswp_pkg::BITOP_SET);
        chk("user set", PROGRAM_STATUS_WORD[15], 1'b1);
        bop(1'b1, 3'h7, cswp_pkg::BITOP_MOV);
        @(posedge CLK);
        #1;
        chk("bit acc", {PROGRAM_STATUS_WORD[0], BIT_ACC}, 2'b11);
        bop(1'b0, 3'h0, cswp_pkg::BITOP_NOT);
        bop(1'b1, 3'h7, cswp_pkg::BITOP_CLR);
        chk("bit ops", {PROGRAM_STATUS_WORD[15], PROGRAM_STATUS_WORD[0]}, 2'b00);
    endtask

    initial begin
        CLK = 1'b0;
        SYS_RST = 1'b1;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'b000;
        {S_AXI_ARVALID, S_AXI_RREADY, RESET_VEC_VALID, FETCH_ADV} = 4'h0;
        {BRANCH, MASKABLE_REQ, NMI_REQ, MACRO_REQ} = 4'h0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
        {FETCH_LEN, BANK_SEL, RESTORE_WORD} = '0;
        RESET_VEC = 16'hA5C3;
        BRANCH_TARGET = 20'hF_FFFE;
        ALU = '0;
        BITOP = '0;
        EVENT = cswp_pkg::CSWP_EV_NONE;
        error_cnt = 0;
        tests_run = 0;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_regs;
        t_pc;
        t_events;
        t_alu;
        @(posedge CLK);
        SYS_RST <= 1'b1;
        @(posedge CLK);
        SYS_RST <= 1'b0;
        #1;
        chk("rerun reset", PROGRAM_STATUS_WORD, 16'h0000);
        summarize;
    end
endmodule
`default_nettype wire
